// File: pkg/fser_pkg.sv
package fser_pkg;

  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;

  // Port select on the parallel bus
  localparam logic SEL_CSR  = 1'b0;
  localparam logic SEL_DATA = 1'b1;

  // command_status_word bit positions
  localparam int CS_GO      = 0;
  localparam int CS_FUNC_LO = 1;
  localparam int CS_UNIT    = 4;
  localparam int CS_DONE    = 5;
  localparam int CS_IE      = 6;
  localparam int CS_XFER    = 7;
  localparam int CS_INIT    = 14;
  localparam int CS_ERR     = 15;

  // drive_condition_flags bit positions
  localparam int FL_CRC = 0;
  localparam int FL_PAR = 1;
  localparam int FL_INI = 2;
  localparam int FL_DEL = 6;
  localparam int FL_RDY = 7;

  // Function codes
  localparam logic [2:0] FN_FILL   = 3'h0;
  localparam logic [2:0] FN_EMPTY  = 3'h1;
  localparam logic [2:0] FN_WRITE  = 3'h2;
  localparam logic [2:0] FN_READ   = 3'h3;
  localparam logic [2:0] FN_STATUS = 3'h5;
  localparam logic [2:0] FN_WRDEL  = 3'h6;
  localparam logic [2:0] FN_ERRREG = 3'h7;

  // failure_code values (octal 150 and 200)
  localparam logic [7:0] CODE_TRACK_MISMATCH = 8'h68;
  localparam logic [7:0] CODE_DATA_CRC       = 8'h80;

  // Address ranges (octal 114 tracks, octal 32 sectors)
  localparam logic [7:0] TRACK_COUNT  = 8'h4C;
  localparam logic [7:0] SECTOR_COUNT = 8'h1A;

  // What the media engine wants from the host next
  localparam logic [1:0] WANT_DATA   = 2'h0;
  localparam logic [1:0] WANT_SECTOR = 2'h1;
  localparam logic [1:0] WANT_TRACK  = 2'h2;

  // Reset values
  localparam logic        IE_RST    = 1'b0;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [7:0]  CODE_RST  = 8'h00;
  localparam logic [15:0] DATA_RST  = 16'h0000;
  localparam logic [7:0]  ADDR_RST  = 8'h00;

  typedef struct packed {
    logic exists;
    logic powered;
    logic media_in;
    logic door_closed;
    logic up_to_speed;
  } fser_drive_type;

  typedef struct packed {
    logic       done;
    logic       fail;
    logic       crc_err;
    logic       parity_err;
    logic       deleted;
    logic       init_done;
    logic       track_mismatch;
    logic       code_load;
    logic [7:0] code;
  } fser_evt_type;

  typedef struct packed {
    logic [2:0] func;
    logic       unit;
    logic       init;
  } fser_cmd_type;

endpackage

// File: rtl/fser_buf.sv
`timescale 1ns/1ps
`default_nettype none
module fser_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
      $error("fser_buf: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg < FULL);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: rtl/fser_regs.sv
// What this block does
// - All media bytes pass through data port
// - Track select keeps low byte only
// - Sector select keeps low byte only
// - Flags describe the unit-selected drive
// - Condition flags are read-only, protocol reached
// - Completion copies flags into data port, except function 111
// - Data CRC failure sets bit 0, error, done
// - Parity error sets bit 1, aborts function
// - Initialize completion sets bit 2
// - Deleted data mark sets bit 6
// - Ready bit only when drive fully ready
// - Read-only failure code register kept
// - Track mismatch loads failure code 150
// - Data CRC failure loads failure code 200
// - Busy data port works only under transfer request
// - Error bit set on failure, cleared on start
// - Function 111 copies failure code, then done
`timescale 1ns/1ps
`default_nettype none
module fser_regs #(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    bus_sel,
  input  wire logic                    bus_wr,
  input  wire logic                    bus_rd,
  input  wire logic [15:0]             bus_wdata,
  output logic      [15:0]             bus_rdata,
  output logic                         cmd_start,
  output fser_pkg::fser_cmd_type       cmd,
  output logic                         cmd_abort,
  output logic      [7:0]              track_addr,
  output logic      [7:0]              sector_addr,
  output logic                         addr_ok,
  input  wire logic                    want_byte,
  input  wire logic [1:0]              want_kind,
  output logic                         host_byte_valid,
  output logic      [7:0]              host_byte,
  input  wire logic                    src_valid,
  input  wire logic [7:0]              src_data,
  output logic                         src_ready,
  input  wire fser_pkg::fser_evt_type  evt,
  input  wire fser_pkg::fser_drive_type drive0,
  input  wire fser_pkg::fser_drive_type drive1
);
  import fser_pkg::*;

  initial begin
    if (BUF_DEPTH < 2)
      $error("fser_regs: BUF_DEPTH must be at least 2");
  end

  function automatic logic drive_ready(input fser_drive_type d);
    drive_ready = d.exists && d.powered && d.media_in
                  && d.door_closed && d.up_to_speed;
  endfunction

  typedef enum logic [1:0] {S_IDLE, S_ENGINE, S_LOCAL, S_INIT} fser_state_type;

  ////////////////////////////////////////////////////////////////////////
  fser_state_type state_reg;
  logic           ie_reg;
  logic           done_reg;
  logic           err_reg;
  logic [7:0]     flags_reg;
  logic [7:0]     flags_next;
  logic [7:0]     code_reg;
  logic [15:0]    data_reg;
  logic [15:0]    rdata_reg;
  logic [7:0]     track_reg;
  logic [7:0]     sector_reg;
  logic           hb_valid_reg;
  logic [7:0]     hb_reg;
  logic           start_reg;
  logic           abort_reg;
  fser_cmd_type   cmd_reg;

  logic       busy;
  logic       buf_valid;
  logic [7:0] buf_data;
  logic       buf_pop;
  logic       transfer_request;
  logic       csr_wr;
  logic       data_wr;
  logic       data_rd;
  logic       go;
  logic       init_go;
  logic       finish;
  logic       fail_now;
  logic       sel_ready;

  assign busy     = (state_reg != S_IDLE);
  assign csr_wr   = bus_wr && (bus_sel == SEL_CSR);
  assign data_wr  = bus_wr && (bus_sel == SEL_DATA);
  assign data_rd  = bus_rd && (bus_sel == SEL_DATA);
  assign init_go  = csr_wr && bus_wdata[CS_INIT];
  assign go       = csr_wr && bus_wdata[CS_GO] && !busy && !init_go;
  // Engine must drop want_byte on the cycle host_byte_valid is seen
  assign transfer_request =
    busy && ((want_byte && !hb_valid_reg) || buf_valid);
  assign buf_pop  = data_rd && busy && buf_valid;
  assign sel_ready = cmd_reg.unit ? drive_ready(drive1)
                                  : drive_ready(drive0);
  assign fail_now = evt.fail || evt.parity_err || evt.crc_err;
  assign finish = (state_reg == S_ENGINE && (evt.done || evt.parity_err))
               || (state_reg == S_LOCAL)
               || (state_reg == S_INIT && evt.init_done);

  ////////////////////////////////////////////////////////////////////////
  // Media-to-host bytes; a slow host stalls the engine, not loses bytes
  fser_buf #(.WIDTH(BYTE_W), .DEPTH(BUF_DEPTH)) fser_buf_inst (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (src_valid),
    .in_data   (src_data),
    .in_ready  (src_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (buf_pop)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
      cmd_reg   <= '0;
    end else begin
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
      if (init_go) begin
        state_reg    <= S_INIT;
        start_reg    <= 1'b1;
        cmd_reg      <= '0;
        cmd_reg.init <= 1'b1;
      end else if (go) begin
        cmd_reg.func <= bus_wdata[CS_FUNC_LO +: 3];
        cmd_reg.unit <= bus_wdata[CS_UNIT];
        cmd_reg.init <= 1'b0;
        start_reg    <= 1'b1;
        if (bus_wdata[CS_FUNC_LO +: 3] == FN_STATUS ||
            bus_wdata[CS_FUNC_LO +: 3] == FN_ERRREG)
          state_reg <= S_LOCAL;
        else
          state_reg <= S_ENGINE;
      end else if (finish) begin
        state_reg <= S_IDLE;
        abort_reg <= (state_reg == S_ENGINE) && evt.parity_err;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control bits of command_status_word
  always_ff @(posedge clk) begin
    if (rst) begin
      ie_reg   <= IE_RST;
      done_reg <= 1'b1;
      err_reg  <= 1'b0;
    end else begin
      if (csr_wr && !busy)
        ie_reg <= bus_wdata[CS_IE];
      if (go || init_go) begin
        done_reg <= 1'b0;
        err_reg  <= 1'b0;
      end
      // Set after clear so a coincident failure is never lost
      if (finish) begin
        done_reg <= 1'b1;
        if (state_reg == S_ENGINE && fail_now)
          err_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // drive_condition_flags
  always_comb begin
    flags_next = flags_reg;
    if (go && (bus_wdata[CS_FUNC_LO +: 3] == FN_WRITE ||
               bus_wdata[CS_FUNC_LO +: 3] == FN_WRDEL ||
               bus_wdata[CS_FUNC_LO +: 3] == FN_READ)) begin
      flags_next[FL_CRC] = 1'b0;
      flags_next[FL_PAR] = 1'b0;
      flags_next[FL_DEL] = 1'b0;
    end
    if (state_reg == S_LOCAL && cmd_reg.func == FN_ERRREG)
      flags_next[6:0] = 7'h00;
    if (state_reg == S_ENGINE) begin
      if (evt.crc_err)
        flags_next[FL_CRC] = 1'b1;
      if (evt.parity_err)
        flags_next[FL_PAR] = 1'b1;
      if (evt.deleted)
        flags_next[FL_DEL] = 1'b1;
    end
    if (state_reg == S_INIT && evt.init_done) begin
      flags_next = FLAGS_RST;
      flags_next[FL_INI] = 1'b1;
      flags_next[FL_RDY] = drive_ready(drive0);
    end else if (finish) begin
      flags_next[FL_RDY] = sel_ready;
    end
    flags_next[5:3] = 3'h0;
  end

  always_ff @(posedge clk) begin
    if (rst)
      flags_reg <= FLAGS_RST;
    else
      flags_reg <= flags_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // failure_code, loaded only by the device
  always_ff @(posedge clk) begin
    if (rst) begin
      code_reg <= CODE_RST;
    end else if (state_reg == S_ENGINE) begin
      if (evt.crc_err)
        code_reg <= CODE_DATA_CRC;
      else if (evt.track_mismatch)
        code_reg <= CODE_TRACK_MISMATCH;
      else if (evt.code_load)
        code_reg <= evt.code;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // media_data_port, track_select, sector_select, engine byte strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      data_reg     <= DATA_RST;
      track_reg    <= ADDR_RST;
      sector_reg   <= ADDR_RST;
      hb_valid_reg <= 1'b0;
      hb_reg       <= 8'h00;
    end else begin
      hb_valid_reg <= 1'b0;
      if (finish) begin
        if (state_reg == S_LOCAL && cmd_reg.func == FN_ERRREG)
          data_reg <= {8'h00, code_reg};
        else
          data_reg <= {8'h00, flags_next};
      end else if (data_wr && !busy) begin
        data_reg <= bus_wdata;
      end else if (data_wr && transfer_request && !buf_valid) begin
        data_reg     <= bus_wdata;
        hb_valid_reg <= 1'b1;
        hb_reg       <= bus_wdata[7:0];
        if (want_kind == WANT_TRACK)
          track_reg <= bus_wdata[7:0];
        if (want_kind == WANT_SECTOR)
          sector_reg <= bus_wdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data; a busy read without transfer request returns stale data
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
    end else if (bus_rd) begin
      if (bus_sel == SEL_CSR)
        rdata_reg <= {err_reg, 7'h00, transfer_request, ie_reg,
                      done_reg, 5'h00};
      else if (buf_pop)
        rdata_reg <= {8'h00, buf_data};
      else
        rdata_reg <= data_reg;
    end
  end

  assign bus_rdata       = rdata_reg;
  assign cmd_start       = start_reg;
  assign cmd             = cmd_reg;
  assign cmd_abort       = abort_reg;
  assign track_addr      = track_reg;
  assign sector_addr     = sector_reg;
  assign addr_ok = (track_reg < TRACK_COUNT) && (sector_reg < SECTOR_COUNT);
  assign host_byte_valid = hb_valid_reg;
  assign host_byte       = hb_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_issue_errreg;
    go && bus_wdata[CS_FUNC_LO +: 3] == FN_ERRREG;
  endsequence

  sequence s_errreg_done;
    done_reg && data_reg == {8'h00, $past(code_reg)};
  endsequence

  sequence s_issue_status;
    go && bus_wdata[CS_FUNC_LO +: 3] == FN_STATUS;
  endsequence

  chk_errreg_copy: assert property (@(posedge clk)
    disable iff (rst) s_issue_errreg |-> ##2 s_errreg_done)
    else $error("error code not moved to data port");

  chk_status_unit: assert property (@(posedge clk)
    disable iff (rst) s_issue_status ##1 !cmd_reg.unit
      |=> done_reg && flags_reg[FL_RDY] == $past(drive_ready(drive0)))
    else $error("status ready bit not from chosen unit");

  chk_crc_flag: assert property (@(posedge clk) disable iff (rst)
    state_reg == S_ENGINE && evt.crc_err && evt.done
      |=> flags_reg[FL_CRC] && err_reg && done_reg
          && data_reg[7:0] == flags_reg)
    else $error("crc failure not reported");

  chk_parity_abort: assert property (@(posedge clk)
    disable iff (rst) state_reg == S_ENGINE && evt.parity_err
      |=> state_reg == S_IDLE && cmd_abort && flags_reg[FL_PAR] && err_reg)
    else $error("parity error did not end function");

  chk_crc_code: assert property (@(posedge clk) disable iff (rst)
    state_reg == S_ENGINE && evt.crc_err |=> code_reg == CODE_DATA_CRC)
    else $error("crc failure code wrong");

  chk_track_code: assert property (@(posedge clk) disable iff (rst)
    state_reg == S_ENGINE && evt.track_mismatch && !evt.crc_err
      |=> code_reg == CODE_TRACK_MISMATCH)
    else $error("track mismatch code wrong");

  // An idle host write may leave upper bits; only completion copies count
  chk_unused_zero: assert property (@(posedge clk)
    disable iff (rst) flags_reg[5:3] == 3'h0
      and (finish |=> data_reg[15:8] == 8'h00))
    else $error("unused bits not zero");

  chk_track_low: assert property (@(posedge clk) disable iff (rst)
    data_wr && transfer_request && !buf_valid && want_kind == WANT_TRACK
      |=> track_addr == $past(bus_wdata[7:0]) && host_byte_valid)
    else $error("track select not taken from low byte");

  chk_busy_gate: assert property (@(posedge clk) disable iff (rst)
    data_wr && busy && !transfer_request && !finish
      |=> $stable(data_reg) && !host_byte_valid)
    else $error("data port written without transfer request");

  chk_init_done: assert property (@(posedge clk) disable iff (rst)
    state_reg == S_INIT && evt.init_done |=> flags_reg[FL_INI] && done_reg
      && flags_reg[FL_RDY] == $past(drive_ready(drive0)))
    else $error("initialize completion not flagged");

  chk_err_clear: assert property (@(posedge clk) disable iff (rst)
    go |=> !err_reg && !done_reg)
    else $error("new command did not clear error");

endmodule
`default_nettype wire

// File: tb/fser_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module fser_engine_model (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   cmd_start,
  input  wire fser_pkg::fser_cmd_type cmd,
  input  wire logic                   host_byte_valid,
  input  wire logic                   src_ready,
  input  wire logic [2:0]             fault,
  output logic                        want_byte,
  output logic      [1:0]             want_kind,
  output logic                        src_valid,
  output logic      [7:0]             src_data,
  output fser_pkg::fser_evt_type      evt
);
  import fser_pkg::*;
  int ph;
  int left;
  int cnt;
  ////////////////////////////////////////
  always_ff @(posedge clk) begin
    evt <= '0;
    if (rst) begin
      ph        <= 0;
      cnt       <= 0;
      left      <= 0;
      want_byte <= 1'b0;
      want_kind <= WANT_DATA;
      src_valid <= 1'b0;
      src_data  <= 8'h00;
    end else if (cmd_start) begin
      // Short pause so the host can poke the port before asking
      cnt       <= 3;
      left      <= (cmd.func == FN_EMPTY) ? 3 : 2;
      src_data  <= 8'hA1;
      want_kind <= (cmd.func == FN_FILL) ? WANT_DATA : WANT_SECTOR;
      if (cmd.init)
        ph <= 4;
      else if (cmd.func == FN_EMPTY)
        ph <= 2;
      else if (cmd.func inside {FN_STATUS, FN_ERRREG})
        ph <= 0;
      else
        ph <= 1;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else begin
      case (ph)
        1: begin
          want_byte <= !host_byte_valid;
          if (host_byte_valid) begin
            left <= left - 1;
            cnt  <= 2;
            if (want_kind == WANT_SECTOR)
              want_kind <= WANT_TRACK;
            if (left == 1) begin
              ph  <= 3;
              cnt <= 30;
            end
          end
        end
        2: begin
          src_valid <= 1'b1;
          if (src_valid && src_ready) begin
            src_data <= src_data + 8'h11;
            left     <= left - 1;
            if (left == 1) begin
              // Long gap lets the host drain before completion
              src_valid <= 1'b0;
              ph        <= 3;
              cnt       <= 30;
            end
          end
        end
        3: begin
          ph                 <= 0;
          evt.done           <= (fault != 3'h2);
          evt.fail           <= (fault inside {3'h1, 3'h2, 3'h3});
          evt.crc_err        <= (fault == 3'h1);
          evt.parity_err     <= (fault == 3'h2);
          evt.track_mismatch <= (fault == 3'h3);
          evt.deleted        <= (fault == 3'h4);
        end
        4: begin
          ph            <= 0;
          evt.init_done <= 1'b1;
        end
        default: ph <= 0;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_fser_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fser_regs;
  import fser_pkg::*;
  logic           clk;
  logic           rst;
  logic           bus_sel;
  logic           bus_wr;
  logic           bus_rd;
  logic [15:0]    bus_wdata;
  logic [15:0]    bus_rdata;
  logic           cmd_start;
  fser_cmd_type   cmd;
  logic           cmd_abort;
  logic [7:0]     track_addr;
  logic [7:0]     sector_addr;
  logic           addr_ok;
  logic           want_byte;
  logic [1:0]     want_kind;
  logic           host_byte_valid;
  logic [7:0]     host_byte;
  logic           src_valid;
  logic [7:0]     src_data;
  logic           src_ready;
  fser_evt_type   evt;
  fser_drive_type drive0;
  fser_drive_type drive1;
  logic [2:0]     fault;
  logic [15:0]    rv;
  int             bad_count;
  int             comparisons;
  int             aborts = 0;
  ////////////////////////////////////////
  fser_regs fser_regs_inst (
    .clk(clk), .rst(rst), .bus_sel(bus_sel), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .cmd_start(cmd_start), .cmd(cmd), .cmd_abort(cmd_abort),
    .track_addr(track_addr), .sector_addr(sector_addr), .addr_ok(addr_ok),
    .want_byte(want_byte), .want_kind(want_kind),
    .host_byte_valid(host_byte_valid), .host_byte(host_byte),
    .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
    .evt(evt), .drive0(drive0), .drive1(drive1));
  fser_engine_model fser_engine_model_inst (
    .clk(clk), .rst(rst), .cmd_start(cmd_start), .cmd(cmd),
    .host_byte_valid(host_byte_valid), .src_ready(src_ready),
    .fault(fault), .want_byte(want_byte), .want_kind(want_kind),
    .src_valid(src_valid), .src_data(src_data), .evt(evt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cmd_abort === 1'b1)
      aborts <= aborts + 1;
  end
  ////////////////////////////////////////
  task automatic end_sim();
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Idle edge first, so a strobe is never lowered and raised at once
  task automatic wr(logic sel, logic [15:0] d);
    @(posedge clk);
    #1 bus_sel = sel;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge clk);
    #1 bus_wr = 1'b0;
  endtask
  task automatic rd(logic sel);
    @(posedge clk);
    #1 bus_sel = sel;
    bus_rd = 1'b1;
    @(posedge clk);
    #1 bus_rd = 1'b0;
    rv = bus_rdata;
  endtask
  task automatic wait_cs(int b);
    for (int i = 0; i < 200; i++) begin
      rd(SEL_CSR);
      if (rv[b] === 1'b1)
        return;
    end
    chk("wait", 16'h0001, 16'h0000);
    end_sim();
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    rd(SEL_CSR);
    chk("csr", 16'h0020, rv);
    rd(SEL_DATA);
    chk("data", 16'h0000, rv);
    wr(SEL_DATA, 16'h5AC3);
    rd(SEL_DATA);
    chk("idle", 16'h5AC3, rv);
  endtask
  task automatic t_init();
    wr(SEL_CSR, 16'h4000);
    chk("init", 16'h0003, {14'h0000, cmd_start, cmd.init});
    wait_cs(CS_DONE);
    chk("csr", 16'h0020, rv);
    rd(SEL_DATA);
    chk("flags", 16'h0084, rv);
  endtask
  task automatic t_status(logic u, logic [15:0] e);
    wr(SEL_CSR, {11'h000, u, 4'hB});
    wait_cs(CS_DONE);
    rd(SEL_DATA);
    chk("status", e, rv);
  endtask
  task automatic t_fill();
    wr(SEL_CSR, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      wait_cs(CS_XFER);
      wr(SEL_DATA, 16'hFF5A + 16'(i));
      chk("fill", 16'h015A + 16'(i),
          {7'h00, host_byte_valid, host_byte});
    end
    wait_cs(CS_DONE);
    rd(SEL_DATA);
    chk("flags", 16'h0084, rv);
  endtask
  task automatic t_empty();
    wr(SEL_CSR, 16'h0003);
    // Host holds off so the two-entry buffer must refuse a third byte
    for (int i = 0; i < 200 && src_ready !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk("stall", 16'h0000, {15'h0000, src_ready});
    for (int i = 0; i < 3; i++) begin
      wait_cs(CS_XFER);
      rd(SEL_DATA);
      chk("empty", 16'h00A1 + 16'(i) * 16'h0011, rv);
    end
    wait_cs(CS_DONE);
    rd(SEL_DATA);
    chk("flags", 16'h0084, rv);
  endtask
  task automatic t_sector(logic [2:0] fn, logic [2:0] f,
                          logic [15:0] ecs, logic [15:0] efl);
    int n;
    fault = f;
    n = aborts;
    wr(SEL_CSR, {12'h000, fn, 1'b1});
    wr(SEL_DATA, 16'h0077);
    chk("early", 16'h0000, {15'h0000, host_byte_valid});
    wait_cs(CS_XFER);
    wr(SEL_DATA, 16'hAB05);
    chk("sector", 16'h0105, {7'h00, host_byte_valid, sector_addr});
    wait_cs(CS_XFER);
    wr(SEL_DATA, 16'hFF4B);
    chk("track", 16'h014B, {7'h00, addr_ok, track_addr});
    wait_cs(CS_DONE);
    chk("csr", ecs, rv);
    rd(SEL_DATA);
    chk("flags", efl, rv);
    chk("abort", 16'(f == 3'h2), 16'(aborts - n));
  endtask
  task automatic t_code(logic [15:0] e);
    wr(SEL_CSR, 16'h004F);
    wait_cs(CS_DONE);
    chk("csr", 16'h0060, rv);
    rd(SEL_DATA);
    chk("code", e, rv);
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    bus_sel = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 16'h0000;
    fault = 3'h0;
    drive0 = 5'h1F;
    drive1 = 5'h1E;
    bad_count = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_init();
    t_status(1'b1, 16'h0004);
    t_status(1'b0, 16'h0084);
    t_fill();
    t_empty();
    t_sector(FN_READ, 3'h1, 16'h8020, 16'h0085);
    t_code(16'h0080);
    t_sector(FN_READ, 3'h4, 16'h0020, 16'h00C0);
    t_sector(FN_WRITE, 3'h3, 16'h8020, 16'h0080);
    t_code(16'h0068);
    t_sector(FN_WRDEL, 3'h2, 16'h8020, 16'h0082);
    t_init();
    end_sim();
  end
endmodule
`default_nettype wire
